//--- hw/drt_pkg.sv
// drt_pkg: offsets, field positions, reset values and carriers of the
// two-channel reload timer.
// assumes an 8-bit on-chip I/O space with one-cycle read/write strobes.
package drt_pkg;
    // ========================================
    // register offsets, index [1] is channel 1
    localparam logic [1:0][7:0] OFS_CNT_LO = {8'h14, 8'h0c};
    localparam logic [1:0][7:0] OFS_CNT_HI = {8'h15, 8'h0d};
    localparam logic [1:0][7:0] OFS_RLD_LO = {8'h16, 8'h0e};
    localparam logic [1:0][7:0] OFS_RLD_HI = {8'h17, 8'h0f};
    localparam logic [7:0] OFS_TIMER_CONTROL = 8'h10;
    // ========================================
    // timer_control field positions
    localparam int POS_ZERO_FLAG = 6;
    localparam int POS_IRQ_ENABLE = 4;
    localparam int POS_OUT_CTRL = 2;
    localparam int POS_COUNT_ENABLE = 0;
    // ========================================
    // out_ctrl_hi/out_ctrl_lo codes
    localparam logic [1:0] OUT_ADDR = 2'h0;
    localparam logic [1:0] OUT_TOGGLE = 2'h1;
    localparam logic [1:0] OUT_LOW = 2'h2;
    localparam logic [1:0] OUT_HIGH = 2'h3;
    // ========================================
    // values after reset
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] CNT_RST = 16'hffff;
    localparam logic [7:0] RDATA_RST = 8'h00;
    localparam int PRESCALE_DEF = 20;
    // ========================================
    // carriers between control and channel
    typedef struct packed {
        logic wr_cnt_lo;
        logic wr_cnt_hi;
        logic wr_rld_lo;
        logic wr_rld_hi;
        logic rd_cnt_lo;
        logic rd_cnt_hi;
        logic [7:0] wdata;
    } drt_chan_cmd_t;
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] reload;
        logic [7:0] hi_view;
        logic zero;
    } drt_chan_stat_t;
endpackage

//--- hw/drt_chan.sv
// drt_chan: one 16-bit down counter with its reload register and the
// high-byte snapshot for coherent reads.
// assumes decoded byte strobes and a one-cycle tick from the parent.
`timescale 1ns/10ps
module drt_chan (
    input wire logic clk_in,                      // system clock
    input wire logic rstn_in,                     // sync reset, low
    input wire logic tick_in,                     // prescaled tick
    input wire logic enable_in,                   // count_enable bit
    input wire drt_pkg::drt_chan_cmd_t cmd_in,    // byte strobes
    output drt_pkg::drt_chan_stat_t stat_out      // channel state
);
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] reload;
        logic [7:0] hi_latch;
        logic latched;
        logic zero;
    } drt_chan_state_t;
    drt_chan_state_t st;
    drt_chan_state_t next_st;

    // ========================================
    // counting, reload and byte access
    always_comb begin
        next_st = st;
        next_st.zero = 1'b0;
        if (tick_in && enable_in) begin // RULE6 RULE14
            if (st.count == 16'h0000) begin
                next_st.count = st.reload; // RULE12
            end else begin
                next_st.count = st.count - 16'h0001;
                next_st.zero = (st.count == 16'h0001); // RULE1
            end
        end
        // software writes win over a coincident tick
        if (cmd_in.wr_cnt_lo) begin // RULE13
            next_st.count[7:0] = cmd_in.wdata;
        end
        if (cmd_in.wr_cnt_hi) begin
            next_st.count[15:8] = cmd_in.wdata;
        end
        if (cmd_in.wr_rld_lo) begin
            next_st.reload[7:0] = cmd_in.wdata;
        end
        if (cmd_in.wr_rld_hi) begin
            next_st.reload[15:8] = cmd_in.wdata;
        end
        if (cmd_in.rd_cnt_lo) begin // RULE8
            next_st.hi_latch = st.count[15:8];
            next_st.latched = 1'b1;
        end
        if (cmd_in.rd_cnt_hi || cmd_in.wr_cnt_hi) begin
            next_st.latched = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin // RULE7
            st <= '{count: drt_pkg::CNT_RST, reload: drt_pkg::CNT_RST,
                    hi_latch: 8'h00, latched: 1'b0, zero: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // high byte comes from the snapshot only after a low-byte read
    assign stat_out = '{count: st.count, reload: st.reload,
                        hi_view: st.latched ? st.hi_latch : st.count[15:8],
                        zero: st.zero};
endmodule // drt_chan

//--- hw/drt_top.sv
// drt_top: timer_control register, I/O decode, prescaler, flags,
// interrupt requests and the shared address/timer output pin.
// assumes the cpu gives one-cycle rd/wr strobes on the on-chip I/O bus.
// Operation
// RULE1 - zero reach sets channel zero flag
// RULE2 - flag and enable raise interrupt request
// RULE3 - flag clears after control then count read
// RULE4 - output field selects address, toggle, low, high
// RULE5 - toggle mode inverts pin on channel1 zero
// RULE6 - count only while count enable set
// RULE7 - reset clears control, counts and reloads ones
// RULE8 - low read snapshots high byte
// RULE9 - software avoids reload during reload writes
// RULE10 - software updates reload before next underflow
// RULE11 - pin follows programmed value before first zero
// RULE12 - zero count reloads from reload register
// RULE13 - 16-bit registers accessed as two bytes
// RULE14 - decrement once per prescaled tick
`timescale 1ns/10ps
module drt_top #(
    parameter int PRESCALE = drt_pkg::PRESCALE_DEF
) (
    input wire logic clk_in,            // 250 MHz system clock
    input wire logic rstn_in,           // sync reset, low
    input wire logic [7:0] io_addr_in,  // on-chip I/O address
    input wire logic io_rd_in,          // read strobe, one cycle
    input wire logic io_wr_in,          // write strobe, one cycle
    input wire logic [7:0] io_wdata_in, // write data
    input wire logic addr_bit_in,       // cpu address bit for the pin
    output logic [7:0] io_rdata_out,    // read data, cycle after strobe
    output logic irq_ch0_out,           // channel 0 request, high
    output logic irq_ch1_out,           // channel 1 request, high
    output logic addr_or_timer_out_pin_out // shared pin level
);
    localparam int PRE_W = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE - 1);

    typedef struct packed {
        logic [1:0] zf;
        logic [1:0] ie;
        logic [1:0] oc;
        logic [1:0] ce;
        logic [1:0] armed;
        logic toggle;
        logic tick;
        logic [PRE_W-1:0] pre_cnt;
        logic [7:0] rdata;
        logic [1:0] irq;
        logic pin;
    } drt_top_state_t;
    drt_top_state_t st;
    drt_top_state_t next_st;
    drt_pkg::drt_chan_cmd_t cmd [2];
    drt_pkg::drt_chan_stat_t stat [2];
    logic wr_ctrl;
    logic rd_ctrl;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // ========================================
    // decode and channels
    assign wr_ctrl = io_wr_in && hit(io_addr_in, drt_pkg::OFS_TIMER_CONTROL);
    assign rd_ctrl = io_rd_in && hit(io_addr_in, drt_pkg::OFS_TIMER_CONTROL);

    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        assign cmd[ch] = '{
            wr_cnt_lo: io_wr_in && hit(io_addr_in, drt_pkg::OFS_CNT_LO[ch]),
            wr_cnt_hi: io_wr_in && hit(io_addr_in, drt_pkg::OFS_CNT_HI[ch]),
            wr_rld_lo: io_wr_in && hit(io_addr_in, drt_pkg::OFS_RLD_LO[ch]),
            wr_rld_hi: io_wr_in && hit(io_addr_in, drt_pkg::OFS_RLD_HI[ch]),
            rd_cnt_lo: io_rd_in && hit(io_addr_in, drt_pkg::OFS_CNT_LO[ch]),
            rd_cnt_hi: io_rd_in && hit(io_addr_in, drt_pkg::OFS_CNT_HI[ch]),
            wdata: io_wdata_in};
        drt_chan i_drt_chan (
            .clk_in(clk_in),
            .rstn_in(rstn_in),
            .tick_in(st.tick),
            .enable_in(st.ce[ch]),
            .cmd_in(cmd[ch]),
            .stat_out(stat[ch])
        );
    end

    // ========================================
    // control, flags, pin and read data
    always_comb begin
        next_st = st;
        // single-cycle tick from the divider keeps one clock domain
        next_st.tick = (st.pre_cnt == PRE_LAST); // RULE14
        next_st.pre_cnt = next_st.tick ? '0 : st.pre_cnt + 1'b1;
        if (wr_ctrl) begin
            next_st.ie = io_wdata_in[drt_pkg::POS_IRQ_ENABLE +: 2];
            next_st.oc = io_wdata_in[drt_pkg::POS_OUT_CTRL +: 2]; // RULE4
            next_st.ce = io_wdata_in[drt_pkg::POS_COUNT_ENABLE +: 2]; // RULE6
            // forced level seeds the toggle so switching modes is glitch free
            if (next_st.oc == drt_pkg::OUT_LOW) begin // RULE11
                next_st.toggle = 1'b0;
            end else if (next_st.oc == drt_pkg::OUT_HIGH) begin
                next_st.toggle = 1'b1;
            end
        end
        if (rd_ctrl) begin
            next_st.armed = st.zf; // RULE3
        end
        for (int ch = 0; ch < 2; ch++) begin
            if ((cmd[ch].rd_cnt_lo || cmd[ch].rd_cnt_hi) && st.armed[ch]) begin // RULE3
                next_st.zf[ch] = 1'b0;
                next_st.armed[ch] = 1'b0;
            end
            // a zero event in the clearing cycle is kept
            if (stat[ch].zero) begin // RULE1
                next_st.zf[ch] = 1'b1;
            end
        end
        if (stat[1].zero && next_st.oc == drt_pkg::OUT_TOGGLE) begin // RULE5
            next_st.toggle = ~st.toggle;
        end
        next_st.irq = next_st.zf & next_st.ie; // RULE2
        case (next_st.oc) // RULE4
            drt_pkg::OUT_ADDR: next_st.pin = addr_bit_in;
            drt_pkg::OUT_LOW: next_st.pin = 1'b0;
            drt_pkg::OUT_HIGH: next_st.pin = 1'b1;
            default: next_st.pin = next_st.toggle;
        endcase
        if (io_rd_in) begin
            if (rd_ctrl) begin
                next_st.rdata = {st.zf, st.ie, st.oc, st.ce};
            end else if (cmd[0].rd_cnt_lo) begin // RULE13
                next_st.rdata = stat[0].count[7:0];
            end else if (cmd[0].rd_cnt_hi) begin // RULE8
                next_st.rdata = stat[0].hi_view;
            end else if (cmd[1].rd_cnt_lo) begin
                next_st.rdata = stat[1].count[7:0];
            end else if (cmd[1].rd_cnt_hi) begin
                next_st.rdata = stat[1].hi_view;
            end else if (hit(io_addr_in, drt_pkg::OFS_RLD_LO[0])) begin
                next_st.rdata = stat[0].reload[7:0];
            end else if (hit(io_addr_in, drt_pkg::OFS_RLD_HI[0])) begin
                next_st.rdata = stat[0].reload[15:8];
            end else if (hit(io_addr_in, drt_pkg::OFS_RLD_LO[1])) begin
                next_st.rdata = stat[1].reload[7:0];
            end else if (hit(io_addr_in, drt_pkg::OFS_RLD_HI[1])) begin
                next_st.rdata = stat[1].reload[15:8];
            end else begin
                next_st.rdata = drt_pkg::RDATA_RST;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin // RULE7
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign io_rdata_out = st.rdata;
    assign irq_ch0_out = st.irq[0];
    assign irq_ch1_out = st.irq[1];
    // pin lags the cpu address bit by one flop
    assign addr_or_timer_out_pin_out = st.pin;

    // ========================================
    // assertions
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    AST_FLAG_SET: assert property ( // RULE1
        stat[1].zero |=> st.zf[1] ##1 (st.zf[1] || $past(st.armed[1])))
        else $error("zero flag ch1 not set after zero reach");
    AST_IRQ: assert property ( // RULE2
        ##1 (irq_ch0_out == (st.zf[0] && st.ie[0])))
        else $error("ch0 request does not match flag and enable");
    AST_IRQ_CH0: assert property ( // RULE2
        (stat[0].zero && st.ie[0] && !wr_ctrl) |=> irq_ch0_out)
        else $error("ch0 request missing after zero reach");
    AST_IRQ_CH1: assert property ( // RULE2
        (stat[1].zero && st.ie[1] && !wr_ctrl) |=> irq_ch1_out)
        else $error("ch1 request missing after zero reach");
    AST_CLR_ARMED: assert property ( // RULE3
        $fell(st.zf[0]) |-> $past(st.armed[0])
            && $past(cmd[0].rd_cnt_lo || cmd[0].rd_cnt_hi))
        else $error("ch0 flag cleared without control then count read");
    AST_PIN_FORCED: assert property ( // RULE4
        ((st.oc == drt_pkg::OUT_LOW) |-> !addr_or_timer_out_pin_out)
            and ((st.oc == drt_pkg::OUT_HIGH) |-> addr_or_timer_out_pin_out))
        else $error("forced pin level wrong");
    AST_PIN_ADDR: assert property ( // RULE4
        (st.oc == drt_pkg::OUT_ADDR && !wr_ctrl)
            |=> addr_or_timer_out_pin_out == $past(addr_bit_in))
        else $error("pin does not follow the address bit");
    AST_TOGGLE: assert property ( // RULE5
        (stat[1].zero && st.oc == drt_pkg::OUT_TOGGLE && !wr_ctrl)
            |=> addr_or_timer_out_pin_out != $past(addr_or_timer_out_pin_out))
        else $error("pin did not toggle on ch1 zero");
    AST_HOLD: assert property ( // RULE6
        (!st.ce[0] && !cmd[0].wr_cnt_lo && !cmd[0].wr_cnt_hi)
            |=> $stable(stat[0].count))
        else $error("ch0 counted while disabled");
    AST_RESET: assert property (disable iff (1'b0) // RULE7
        !rstn_in |=> stat[0].count == drt_pkg::CNT_RST
            && stat[1].reload == drt_pkg::CNT_RST && st.oc == drt_pkg::OUT_ADDR
            && st.zf == 2'h0 && st.ce == 2'h0)
        else $error("reset state wrong");
    AST_COHERENT: assert property ( // RULE8
        cmd[0].rd_cnt_lo |=> stat[0].hi_view == $past(stat[0].count[15:8]))
        else $error("high byte not captured at low read");
    AST_RELOAD: assert property ( // RULE12
        (st.tick && st.ce[1] && stat[1].count == 16'h0000
            && !cmd[1].wr_cnt_lo && !cmd[1].wr_cnt_hi)
            |=> stat[1].count == $past(stat[1].reload))
        else $error("ch1 did not reload at zero");
    AST_TICK: assert property ( // RULE14
        st.tick |-> $past(st.pre_cnt) == PRE_LAST)
        else $error("tick not at prescaler end");

    COV_ZERO1: cover property (stat[1].zero ##1 st.zf[1]);
    COV_CLEAR: cover property (rd_ctrl ##[1:20] $fell(st.zf[0]));
    COV_TOGGLE: cover property (st.oc == drt_pkg::OUT_TOGGLE && $changed(st.toggle));
    COV_IRQ0: cover property (stat[0].zero ##1 irq_ch0_out);
endmodule // drt_top

//--- tb/drt_top_tb_top.sv
// drt_top_tb_top: self-checking bench for the two-channel reload timer.
// assumes drt_pkg and drt_top are compiled first; the bench is the only bus master.
`timescale 1ns/10ps
module drt_top_tb_top;
    // short prescale keeps each count span to a few clocks
    localparam int PRESC = 4;
    localparam logic [7:0] CTL = drt_pkg::OFS_TIMER_CONTROL;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] io_addr_in = 8'h00;
    logic io_rd_in = 1'b0;
    logic io_wr_in = 1'b0;
    logic [7:0] io_wdata_in = 8'h00;
    logic addr_bit_in = 1'b0;
    logic [7:0] io_rdata_out;
    logic irq_ch0_out;
    logic irq_ch1_out;
    logic addr_or_timer_out_pin_out;
    int error_cnt = 0;
    int checks = 0;

    drt_top #(.PRESCALE(PRESC)) i_drt_top (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .io_addr_in(io_addr_in),
        .io_rd_in(io_rd_in),
        .io_wr_in(io_wr_in),
        .io_wdata_in(io_wdata_in),
        .addr_bit_in(addr_bit_in),
        .io_rdata_out(io_rdata_out),
        .irq_ch0_out(irq_ch0_out),
        .irq_ch1_out(irq_ch1_out),
        .addr_or_timer_out_pin_out(addr_or_timer_out_pin_out)
    );

    initial begin
        forever #2 clk_in = ~clk_in;
    end

    // ========================================
    // bus and compare helpers
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        io_addr_in <= a;
        io_wdata_in <= d;
        io_wr_in <= 1'b1;
        @(posedge clk_in);
        io_wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        io_addr_in <= a;
        io_rd_in <= 1'b1;
        @(posedge clk_in);
        io_rd_in <= 1'b0;
        #1;
        d = io_rdata_out;
    endtask

    // low byte first so the high byte comes from the snapshot
    task automatic rd16(input logic [7:0] lo, input logic [7:0] hi, output logic [15:0] v);
        logic [7:0] b0;
        logic [7:0] b1;
        rd(lo, b0);
        rd(hi, b1);
        v = {b1, b0};
    endtask

    task automatic wr16(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] v);
        wr(lo, v[7:0]);
        wr(hi, v[15:8]);
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wait_irq(input int ch);
        for (int i = 0; i < 100; i++) begin
            @(posedge clk_in);
            if ((ch == 1 ? irq_ch1_out : irq_ch0_out) === 1'b1) break;
        end
        #1;
    endtask

    // ========================================
    // scenarios
    task automatic t_reset();
        logic [7:0] d;
        logic [15:0] v;
        rd(CTL, d);
        chk({8'h00, d}, {8'h00, drt_pkg::CTRL_RST}, "control after reset");
        for (int ch = 0; ch < 2; ch++) begin
            rd16(drt_pkg::OFS_CNT_LO[ch], drt_pkg::OFS_CNT_HI[ch], v);
            chk(v, drt_pkg::CNT_RST, "count after reset");
            rd16(drt_pkg::OFS_RLD_LO[ch], drt_pkg::OFS_RLD_HI[ch], v);
            chk(v, drt_pkg::CNT_RST, "reload after reset");
        end
        rd(8'h11, d);
        chk({8'h00, d}, 16'h0000, "unmapped read");
        // flag bits are read only
        wr(CTL, 8'hc0);
        rd(CTL, d);
        chk({8'h00, d}, 16'h0000, "flag write ignored");
        @(posedge clk_in);
        addr_bit_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk({15'h0, addr_or_timer_out_pin_out}, 16'h0001, "address mode pin");
    endtask

    task automatic t_count0();
        logic [7:0] d;
        logic [15:0] v;
        wr16(drt_pkg::OFS_RLD_LO[0], drt_pkg::OFS_RLD_HI[0], 16'h0005);
        wr16(drt_pkg::OFS_CNT_LO[0], drt_pkg::OFS_CNT_HI[0], 16'h0001);
        wr(CTL, 8'h11);
        wait_irq(0);
        chk({15'h0, irq_ch0_out}, 16'h0001, "irq ch0 on zero");
        wr(CTL, 8'h01);
        repeat (2) @(posedge clk_in);
        chk({15'h0, irq_ch0_out}, 16'h0000, "irq ch0 masked");
        rd16(drt_pkg::OFS_CNT_LO[0], drt_pkg::OFS_CNT_HI[0], v);
        chk({15'h0, v <= 16'h0005}, 16'h0001, "count reloaded");
        // count read without a control read first must not clear
        wr(CTL, 8'h10);
        repeat (2) @(posedge clk_in);
        chk({15'h0, irq_ch0_out}, 16'h0001, "flag kept");
        rd(CTL, d);
        chk({15'h0, d[6]}, 16'h0001, "flag ch0 bit");
        rd(drt_pkg::OFS_CNT_HI[0], d);
        repeat (2) @(posedge clk_in);
        chk({15'h0, irq_ch0_out}, 16'h0000, "flag cleared");
        rd(CTL, d);
        chk({8'h00, d}, 16'h0010, "control after clear");
        wr16(drt_pkg::OFS_CNT_LO[0], drt_pkg::OFS_CNT_HI[0], 16'h1234);
        repeat (20) @(posedge clk_in);
        rd16(drt_pkg::OFS_CNT_LO[0], drt_pkg::OFS_CNT_HI[0], v);
        chk(v, 16'h1234, "stopped count holds");
    endtask

    task automatic t_coherent();
        logic [15:0] v;
        logic [15:0] prev;
        // four start phases against the prescaler, so at least one pass
        // sees a tick between the low and the high read at 0100
        for (int p = 0; p < 4; p++) begin
            wr(CTL, 8'h00);
            wr16(drt_pkg::OFS_CNT_LO[1], drt_pkg::OFS_CNT_HI[1], 16'h0101);
            wr(CTL, 8'h02);
            repeat (p) @(posedge clk_in);
            prev = 16'h0101;
            for (int i = 0; i < 3; i++) begin
                rd16(drt_pkg::OFS_CNT_LO[1], drt_pkg::OFS_CNT_HI[1], v);
                chk({15'h0, v <= prev && v + 16'h0003 >= prev}, 16'h0001, "coherent read");
                prev = v;
            end
        end
        wr(CTL, 8'h00);
    endtask

    task automatic t_pin();
        // reload settled while stopped, long before the first underflow
        wr16(drt_pkg::OFS_RLD_LO[1], drt_pkg::OFS_RLD_HI[1], 16'h0002);
        wr16(drt_pkg::OFS_CNT_LO[1], drt_pkg::OFS_CNT_HI[1], 16'h0002);
        wr(CTL, 8'h08);
        repeat (2) @(posedge clk_in);
        chk({15'h0, addr_or_timer_out_pin_out}, 16'h0000, "forced low");
        wr(CTL, 8'h0c);
        repeat (2) @(posedge clk_in);
        chk({15'h0, addr_or_timer_out_pin_out}, 16'h0001, "forced high");
        wr(CTL, 8'h26);
        repeat (2) @(posedge clk_in);
        chk({15'h0, addr_or_timer_out_pin_out}, 16'h0001, "before first zero");
        wait_irq(1);
        chk({15'h0, irq_ch1_out}, 16'h0001, "irq ch1 on zero");
        repeat (2) @(posedge clk_in);
        chk({15'h0, addr_or_timer_out_pin_out}, 16'h0000, "toggled");
        wr(CTL, 8'h00);
        // pin was toggled low, so a high address bit proves the switch
        addr_bit_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk({15'h0, addr_or_timer_out_pin_out}, 16'h0001, "address mode again");
        chk({15'h0, irq_ch1_out}, 16'h0000, "irq ch1 masked");
    endtask

    // ========================================
    // sequence, watchdog and verdict
    task automatic wrap_up();
        if (error_cnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk_in);
        rstn_in <= 1'b1;
        t_reset();
        t_count0();
        t_coherent();
        t_pin();
        wrap_up();
    end

    // the whole run needs well under a thousand clocks
    initial begin
        repeat (5000) @(posedge clk_in);
        error_cnt++;
        $display("MISMATCH %0t watchdog expired", $time);
        wrap_up();
    end
endmodule // drt_top_tb_top
